// >>> verilog/protocol_select_and_node_address.sv
// protocol-select latch, register port, access gating and node address
`timescale 1ns/1ns
module protocol_select_and_node_address (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // otp contents, stable from reset
    input wire logic [2:0] otp_select_i,
    input wire logic [3:0] otp_node_i,
    input wire logic region_two_locked_i,
    // psi5 engine status
    input wire logic psi5_init3_done_i,
    // register port a (primary protocol engine)
    input wire logic a_req_i,
    input wire logic a_we_i,
    input wire logic [7:0] a_addr_i,
    input wire logic [7:0] a_wdata_i,
    // register port b (spi engine)
    input wire logic b_req_i,
    input wire logic b_we_i,
    input wire logic b_test_entry_i,
    input wire logic [7:0] b_addr_i,
    input wire logic [7:0] b_wdata_i,
    // dsi3 discovery and command-response address assignment
    input wire logic disc_valid_i,
    input wire logic [3:0] disc_addr_i,
    // register answer
    output logic rvalid_o,
    output logic [7:0] rdata_o,
    output logic b_refused_o,
    // active configuration
    output logic [2:0] active_select_o,
    output logic [2:0] stored_select_o,
    output logic dsi3_en_o,
    output logic psi5_en_o,
    output logic spi_en_o,
    output logic i2c_en_o,
    output logic arm_allow_o,
    output logic bus_uv_en_o,
    output logic buffered_supply_uv_en_o,
    // node address in use
    output logic [3:0] node_address_o,
    output logic node_address_valid_o
);
    // whole module state in one record
    typedef struct packed {
        logic boot;
        logic [2:0] active_sel;
        logic [2:0] stored_sel;
        logic [3:0] node;
        logic node_valid;
        logic pend_a;
        logic pend_a_we;
        logic [7:0] pend_a_addr;
        logic [7:0] pend_a_wdata;
        logic rvalid;
        logic [7:0] rdata;
        logic b_refused;
        logic dsi3_en;
        logic psi5_en;
        logic spi_en;
        logic i2c_en;
        logic arm_allow;
        logic bus_uv_en;
        logic buf_uv;
        logic node_valid_out;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // decoded view of the active code
    logic dec_dsi3;
    logic dec_psi5;
    logic dec_spi;
    logic dec_i2c;
    logic dec_arm;
    logic dec_uv;

    protocol_decode u_decode (
        .sel_i(state_reg.active_sel),
        .dsi3_en_o(dec_dsi3),
        .psi5_en_o(dec_psi5),
        .spi_en_o(dec_spi),
        .i2c_en_o(dec_i2c),
        .arm_allow_o(dec_arm),
        .bus_uv_en_o(dec_uv)
    );

    // one register access: write effects and read data
    function automatic state_t do_access(input state_t s, input logic we, input logic [7:0] addr,
                                         input logic [7:0] wdata);
        state_t r;
        r = s;
        r.rvalid = 1'b1;
        r.rdata = 8'h00;
        if (addr == commsel_pkg::PROTOCOL_SELECT_ADDR) begin
            // store only; active code untouched until reset
            if (we) begin
                r.stored_sel = wdata[2:0];
            end
            r.rdata = {5'h00, s.stored_sel} & commsel_pkg::SEL_FIELD_MASK;
        end else if (addr == commsel_pkg::NODE_ADDRESS_ADDR) begin
            // node address written by register access
            if (we) begin
                r.node = wdata[3:0];
            end
            r.rdata = {4'h0, s.node} & commsel_pkg::NODE_FIELD_MASK;
        end
        return r;
    endfunction

    // next-state logic
    always_comb begin
        logic b_ok;
        logic dual;
        b_ok = 1'b0;
        dual = 1'b0;
        state_next = state_reg;
        state_next.rvalid = 1'b0;
        state_next.b_refused = 1'b0;
        if (state_reg.boot) begin
            // latch stored code as active configuration
            state_next.boot = 1'b0;
            state_next.active_sel = otp_select_i;
            state_next.stored_sel = otp_select_i;
            // reset reload when region two locked or otp node address nonzero
            if (region_two_locked_i || (otp_node_i != commsel_pkg::NODE_ZERO)) begin
                state_next.node = otp_node_i;
            end
            state_next.node_valid = (otp_node_i != commsel_pkg::NODE_ZERO);
        end else begin
            // active code is never rewritten here
            dual = (state_reg.active_sel == commsel_pkg::SEL_DSI3_SPI) ||
                   (state_reg.active_sel == commsel_pkg::SEL_PSI5_SPI);
            // port b allowed only when spi active
            b_ok = dec_spi && b_req_i;
            if (state_reg.active_sel == commsel_pkg::SEL_PSI5_SPI) begin
                // spi held off until init3, test entry exempt
                if (!psi5_init3_done_i && !b_test_entry_i) begin
                    b_ok = 1'b0;
                end
                if (b_we_i) begin
                    b_ok = 1'b0;
                end
            end
            state_next.b_refused = b_req_i && !b_ok;
            // older held request from a is served first
            if (state_reg.pend_a) begin
                state_next = do_access(state_next, state_reg.pend_a_we, state_reg.pend_a_addr,
                                       state_reg.pend_a_wdata);
                state_next.pend_a = 1'b0;
                if (a_req_i) begin
                    state_next.pend_a = 1'b1;
                    state_next.pend_a_we = a_we_i;
                    state_next.pend_a_addr = a_addr_i;
                    state_next.pend_a_wdata = a_wdata_i;
                end
            end else if (b_ok) begin
                // same-cycle tie: b served now, a held one cycle in the dual spi modes, dropped otherwise
                state_next = do_access(state_next, b_we_i, b_addr_i, b_wdata_i);
                if (a_req_i && dual) begin
                    state_next.pend_a = 1'b1;
                    state_next.pend_a_we = a_we_i;
                    state_next.pend_a_addr = a_addr_i;
                    state_next.pend_a_wdata = a_wdata_i;
                end
            end else if (a_req_i) begin
                state_next = do_access(state_next, a_we_i, a_addr_i, a_wdata_i);
            end
            // discovery only when no otp address
            if (disc_valid_i && dec_dsi3 && (otp_node_i == commsel_pkg::NODE_ZERO)) begin
                state_next.node = disc_addr_i;
                state_next.node_valid = 1'b1;
            end
        end
        state_next.dsi3_en = dec_dsi3 && !state_reg.boot;
        state_next.psi5_en = dec_psi5 && !state_reg.boot;
        state_next.spi_en = dec_spi && !state_reg.boot;
        state_next.i2c_en = dec_i2c && !state_reg.boot;
        state_next.arm_allow = dec_arm && !state_reg.boot;
        state_next.bus_uv_en = dec_uv && !state_reg.boot;
        state_next.buf_uv = !state_next.bus_uv_en;
        state_next.node_valid_out = state_next.node_valid && state_next.dsi3_en;
    end

    // state register; reset values are constants only
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= '0;
            state_reg.boot <= 1'b1;
            state_reg.node <= commsel_pkg::NODE_ADDRESS_RESET[3:0];
            // buffered supply monitor stays armed through reset, no bus monitor yet
            state_reg.buf_uv <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign rvalid_o = state_reg.rvalid;
    assign rdata_o = state_reg.rdata;
    assign b_refused_o = state_reg.b_refused;
    assign active_select_o = state_reg.active_sel;
    assign stored_select_o = state_reg.stored_sel;
    assign dsi3_en_o = state_reg.dsi3_en;
    assign psi5_en_o = state_reg.psi5_en;
    assign spi_en_o = state_reg.spi_en;
    assign i2c_en_o = state_reg.i2c_en;
    assign arm_allow_o = state_reg.arm_allow;
    assign bus_uv_en_o = state_reg.bus_uv_en;
    // buffered supply monitor replaces bus monitor
    assign buffered_supply_uv_en_o = state_reg.buf_uv;
    // node address only meaningful in dsi3
    assign node_address_o = state_reg.node;
    assign node_address_valid_o = state_reg.node_valid_out;
endmodule

// >>> verilog/commsel_pkg.sv
// constants for the protocol-select and node-address register bank
package commsel_pkg;
    // register byte offsets on the internal register port
    localparam logic [7:0] PROTOCOL_SELECT_ADDR = 8'h16;
    localparam logic [7:0] NODE_ADDRESS_ADDR = 8'h18;
    // field layout
    localparam int SEL_W = 3;
    localparam int NODE_W = 4;
    localparam logic [7:0] SEL_FIELD_MASK = 8'h07;
    localparam logic [7:0] NODE_FIELD_MASK = 8'h0f;
    localparam logic [7:0] NODE_ADDRESS_RESET = 8'h00;
    // select codes
    localparam logic [2:0] SEL_DSI3_SPI = 3'h0;
    localparam logic [2:0] SEL_PSI5_SPI = 3'h1;
    localparam logic [2:0] SEL_SPI_A = 3'h2;
    localparam logic [2:0] SEL_DSI3 = 3'h3;
    localparam logic [2:0] SEL_SPI_B = 3'h4;
    localparam logic [2:0] SEL_PSI5 = 3'h5;
    localparam logic [2:0] SEL_I2C_A = 3'h6;
    localparam logic [2:0] SEL_I2C_B = 3'h7;
    localparam logic [3:0] NODE_ZERO = 4'h0;
    // arbiter request sources
    typedef enum logic [1:0] {SRC_NONE, SRC_A, SRC_B} src_t;
endpackage

// >>> verilog/protocol_decode.sv
// pure decode of a select code into protocol, arming and monitor enables
`timescale 1ns/1ns
module protocol_decode (
    // select code in
    input wire logic [2:0] sel_i,
    // decoded enables
    output logic dsi3_en_o,
    output logic psi5_en_o,
    output logic spi_en_o,
    output logic i2c_en_o,
    output logic arm_allow_o,
    output logic bus_uv_en_o
);
    always_comb begin
        dsi3_en_o = 1'b0;
        psi5_en_o = 1'b0;
        spi_en_o = 1'b0;
        i2c_en_o = 1'b0;
        case (sel_i)
            commsel_pkg::SEL_DSI3_SPI: begin
                dsi3_en_o = 1'b1;
                spi_en_o = 1'b1;
            end
            commsel_pkg::SEL_PSI5_SPI: begin
                psi5_en_o = 1'b1;
                spi_en_o = 1'b1;
            end
            commsel_pkg::SEL_SPI_A, commsel_pkg::SEL_SPI_B: begin
                spi_en_o = 1'b1;
            end
            commsel_pkg::SEL_DSI3: begin
                dsi3_en_o = 1'b1;
            end
            commsel_pkg::SEL_PSI5: begin
                psi5_en_o = 1'b1;
            end
            default: begin
                i2c_en_o = 1'b1;
            end
        endcase
        arm_allow_o = spi_en_o;
        // bus monitor for single bus-line protocols
        bus_uv_en_o = (sel_i == commsel_pkg::SEL_DSI3) || (sel_i == commsel_pkg::SEL_PSI5);
    end
endmodule

// >>> tb/psna_sva.sv
// port assertions for the protocol-select and node-address bank
`timescale 1ns/1ns
module psna_sva (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // watched inputs
    input wire logic psi5_init3_done_i,
    input wire logic a_req_i,
    input wire logic a_we_i,
    input wire logic b_req_i,
    input wire logic b_we_i,
    input wire logic b_test_entry_i,
    input wire logic disc_valid_i,
    input wire logic [7:0] a_addr_i,
    input wire logic [7:0] a_wdata_i,
    input wire logic [3:0] otp_node_i,
    input wire logic [3:0] disc_addr_i,
    // watched outputs
    input wire logic [3:0] node_address_o,
    input wire logic [2:0] active_select_o,
    input wire logic rvalid_o,
    input wire logic b_refused_o,
    input wire logic dsi3_en_o,
    input wire logic psi5_en_o,
    input wire logic spi_en_o,
    input wire logic i2c_en_o,
    input wire logic arm_allow_o,
    input wire logic bus_uv_en_o,
    input wire logic buffered_supply_uv_en_o,
    input wire logic node_address_valid_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // latched code; enables only settle on the second edge after release
    wire logic [2:0] s = active_select_o;
    a_decode_protocols: assert property ($past(resetn_i, 2) |->
        {dsi3_en_o, psi5_en_o, spi_en_o, i2c_en_o} == {s inside {3'h0, 3'h3}, s inside {3'h1, 3'h5},
        s inside {3'h0, 3'h1, 3'h2, 3'h4}, s[2] & s[1]}) else $error("protocol enables wrong");
    a_arming_gate: assert property ($past(resetn_i, 2) |->
        arm_allow_o == (s inside {3'h0, 3'h1, 3'h2, 3'h4})) else $error("arming gate wrong");
    a_monitor_select: assert property ($past(resetn_i, 2) |->
        bus_uv_en_o == (s inside {3'h3, 3'h5}) && buffered_supply_uv_en_o == !bus_uv_en_o) else $error("monitor wrong");
    a_select_holds: assert property ($past(resetn_i, 2) |-> $stable(active_select_o))
        else $error("active select moved");
    a_early_spi_dropped: assert property (b_req_i && s == 3'h1 && !psi5_init3_done_i && !b_test_entry_i
        |=> b_refused_o) else $error("early spi not dropped");
    a_spi_write_dropped: assert property (b_req_i && b_we_i && s == 3'h1 |=> b_refused_o)
        else $error("spi write not dropped");
    a_tie_both_served: assert property ($past(resetn_i) && a_req_i && b_req_i && !b_we_i && s == 3'h0
        |=> rvalid_o ##1 rvalid_o) else $error("tie not served in turn");
    a_node_write: assert property ($past(resetn_i) && a_req_i && a_we_i && !b_req_i &&
        a_addr_i == commsel_pkg::NODE_ADDRESS_ADDR |=> {4'h0, node_address_o} == ($past(a_wdata_i) & 8'h0f))
        else $error("node write lost");
    a_discovery_taken: assert property ($past(resetn_i) && disc_valid_i && otp_node_i == 4'h0 &&
        dsi3_en_o && !a_req_i && !b_req_i |=> node_address_o == $past(disc_addr_i) && node_address_valid_o)
        else $error("discovered address lost");
    a_valid_needs_dsi3: assert property (node_address_valid_o |-> dsi3_en_o)
        else $error("node address valid outside dsi3");
    // main scenarios reached
    c_tie: cover property (a_req_i && b_req_i);
    c_refused: cover property (b_refused_o);
    c_discovery: cover property (disc_valid_i && dsi3_en_o);
endmodule
bind protocol_select_and_node_address psna_sva chk_i (.*);

// >>> tb/spi_host_model.sv
// spi-side register master driving port b of the bank
`timescale 1ns/1ns
module spi_host_model (
    // clock
    input wire logic clk_i,
    // port b request
    output logic b_req_o,
    output logic b_we_o,
    output logic b_te_o,
    output logic [7:0] b_addr_o,
    output logic [7:0] b_wd_o
);
    initial {b_req_o, b_we_o, b_te_o, b_addr_o, b_wd_o} = '0;
    // one-cycle request; released address and data lines show the inverse, not the old value
    // select never rewritten
    task automatic issue(input logic we, te, input logic [7:0] ad, wd);
        @(posedge clk_i);
        {b_req_o, b_we_o, b_te_o, b_addr_o, b_wd_o} <= {1'b1, we && ad != commsel_pkg::PROTOCOL_SELECT_ADDR, te, ad, wd};
        @(posedge clk_i);
        {b_req_o, b_we_o, b_te_o, b_addr_o, b_wd_o} <= {3'b000, ~ad, ~wd};
    endtask
endmodule

// >>> tb/protocol_select_and_node_address_test.sv
// self-checking bench for the protocol-select and node-address bank
`timescale 1ns/1ns
module protocol_select_and_node_address_test;
    // stimulus and observed outputs
    logic clk_i = 0, resetn_i = 0, lock = 0, init3 = 0, a_req = 0, a_we = 0, disc = 0, b_req, b_we, b_te;
    logic [7:0] a_addr = 0, a_wd = 0, b_addr, b_wd, rdata;
    logic [2:0] osel = 0, act, stored;
    logic [3:0] onode = 0, daddr = 0, node;
    logic [5:0] en;
    logic rvalid, bref, buv, nval;
    int fails = 0, n_checks = 0, cyc = 0;
    logic [31:0] rs = 32'h63b53eea;
    // expected {dsi3, psi5, spi, i2c, arm, bus monitor} for each code
    localparam logic [5:0] EN [8] = '{6'h2a, 6'h1a, 6'h0a, 6'h21, 6'h0a, 6'h11, 6'h04, 6'h04};
    always #5 clk_i = ~clk_i;
    spi_host_model hm (.clk_i(clk_i), .b_req_o(b_req), .b_we_o(b_we), .b_te_o(b_te), .b_addr_o(b_addr), .b_wd_o(b_wd));
    protocol_select_and_node_address DUT (.clk_i(clk_i), .resetn_i(resetn_i), .otp_select_i(osel),
        .otp_node_i(onode), .region_two_locked_i(lock), .psi5_init3_done_i(init3), .a_req_i(a_req), .a_we_i(a_we),
        .a_addr_i(a_addr), .a_wdata_i(a_wd), .b_req_i(b_req), .b_we_i(b_we), .b_test_entry_i(b_te),
        .b_addr_i(b_addr), .b_wdata_i(b_wd), .disc_valid_i(disc), .disc_addr_i(daddr), .rvalid_o(rvalid),
        .rdata_o(rdata), .b_refused_o(bref), .active_select_o(act), .stored_select_o(stored), .dsi3_en_o(en[5]),
        .psi5_en_o(en[4]), .spi_en_o(en[3]), .i2c_en_o(en[2]), .arm_allow_o(en[1]), .bus_uv_en_o(en[0]),
        .buffered_supply_uv_en_o(buv), .node_address_o(node), .node_address_valid_o(nval));
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    task automatic chk(input string n, input logic [7:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // reset with given otp contents; first requests wait for the enables
    task automatic boot(input logic [2:0] c, input logic [3:0] nd, input logic lk, input int n);
        @(posedge clk_i);
        {resetn_i, osel, onode, lock, init3} <= {1'b0, c, nd, lk, 1'b0};
        repeat (n) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic pa(input logic we, input logic [7:0] ad, wd);
        @(posedge clk_i);
        {a_req, a_we, a_addr, a_wd} <= {1'b1, we, ad, wd};
        @(posedge clk_i);
        {a_req, a_we, a_addr, a_wd} <= {2'b00, ~ad, ~wd};
        #1;
    endtask
    // port a access with answer one cycle later
    task automatic acc(input logic we, input logic [7:0] ad, wd, e);
        pa(we, ad, wd);
        chk("a_rvalid", {7'h0, rvalid}, 8'h01);
        chk("a_rdata", rdata, e);
    endtask
    task automatic pb(input logic we, te, input logic [7:0] ad, input logic rf, input logic [7:0] e);
        hm.issue(we, te, ad, rnd());
        #1;
        chk("b_refused", {7'h0, bref}, {7'h0, rf});
        chk("b_rvalid", {7'h0, rvalid}, {7'h0, !rf});
        if (!rf) chk("b_rdata", rdata, e);
    endtask
    task automatic dv(input logic [3:0] d);
        @(posedge clk_i);
        {disc, daddr} <= {1'b1, d};
        @(posedge clk_i);
        {disc, daddr} <= {1'b0, ~d};
        #1;
    endtask
    // cut a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        logic [2:0] cs;
        logic [7:0] nd;
        for (int c = 0; c < 8; c++) begin
            cs = c[2:0];
            boot(cs, 4'h0, 1'b0, c == 0 ? 20 : 2);
            #1;
            chk("active", {5'h0, act}, {5'h0, cs});
            chk("enables", {2'h0, en}, {2'h0, EN[c]});
            chk("buffered_uv", {7'h0, buv}, {7'h0, ~EN[c][0]});
            acc(1'b1, commsel_pkg::PROTOCOL_SELECT_ADDR, {5'h0, ~cs}, {5'h0, cs});
            chk("active_kept", {5'h0, act}, {5'h0, cs});
            chk("stored", {5'h0, stored}, {5'h0, ~cs});
            nd = rnd();
            acc(1'b1, commsel_pkg::NODE_ADDRESS_ADDR, nd, 8'h00);
            acc(1'b0, commsel_pkg::NODE_ADDRESS_ADDR, 8'h00, nd & 8'h0f);
            acc(1'b0, 8'h55, 8'h00, 8'h00);
            pb(1'b0, 1'b0, 8'h16, !EN[c][3] || c == 1, {5'h0, ~cs});
            if (c == 1) begin
                pb(1'b0, 1'b1, 8'h16, 1'b0, {5'h0, ~cs});
                @(posedge clk_i);
                init3 <= 1'b1;
                pb(1'b1, 1'b0, 8'h18, 1'b1, 8'h00);
                pb(1'b0, 1'b0, 8'h18, 1'b0, nd & 8'h0f);
            end
            if (c < 2) begin
                fork
                    pa(1'b0, 8'h18, 8'h00);
                    hm.issue(1'b0, 1'b0, 8'h16, 8'h00);
                join
                chk("tie_b", rdata, {5'h0, ~cs});
                @(posedge clk_i);
                #1;
                chk("tie_a", {rvalid, 3'h0, rdata[3:0]}, {1'b1, 3'h0, nd[3:0]});
            end
        end
        boot(3'h0, 4'h9, 1'b1, 2);
        chk("node_reload", {4'h0, node}, 8'h09);
        boot(3'h0, 4'h0, 1'b0, 2);
        nd = rnd() | 8'h01;
        dv(nd[3:0]);
        chk("discovered", {3'h0, nval, node}, {4'h1, nd[3:0]});
        boot(3'h3, 4'h5, 1'b0, 2);
        dv(4'h3);
        chk("disc_ignored", {3'h0, nval, node}, 8'h15);
        boot(3'h5, 4'h5, 1'b0, 2);
        chk("node_inert", {3'h0, nval, node}, 8'h05);
        end_of_test();
    end
endmodule
